/* fhs_sequencer.sv */
// Frequency hop list sequencer with its table, trigger logic and AXI4-Lite registers.
`default_nettype none
module fhs_sequencer import fhs_pkg::*; (
   input wire logic clock,
   input wire logic resetn,
   input wire fhs_axi_m2s_s axiIn,
   output fhs_axi_s2m_s axiOut,
   input wire logic trigIn,
   output logic trigEcho,
   output logic syncOut,
   output logic freqValid,
   output logic [31:0] freqData,
   input wire logic freqReady
);
   fhs_seq_s r;
   fhs_seq_s n;
   logic [31:0] tableMem [TABLE_DEPTH];
   logic memWe;
   logic [IDX_W-1:0] memAddr;
   logic [31:0] memWd;
   logic [31:0] wd;
   logic advCmd;
   logic manCmd;
   logic extEdge;
   logic lastPoint;
   logic pushValid;
   logic bufReady;
   logic lfsrLoad;
   logic lfsrStep;
   logic [IDX_W-1:0] lfsrState;
   logic [IDX_W-1:0] seqAddr;
   logic [LEN_W-1:0] halfLen;

   // Byte-lane merge so a narrow write leaves the other lanes of a register untouched; FREQ table writes take wData whole, unmerged.
   function automatic logic [31:0] fhsMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction : fhsMerge

   function automatic logic fhsMapped(input logic [ADDR_W-1:0] a);
      return a <= OFS_STAT && a[1:0] == 2'h0;
   endfunction : fhsMapped

   // Read view of every register; also the base of a strobed write.
   function automatic logic [31:0] fhsRead(input fhs_seq_s s, input logic [ADDR_W-1:0] a, input logic [31:0] w);
      logic [31:0] v;
      v = 32'h0;
      if (a == OFS_CTRL) begin
         v = {25'h0, s.ctrl};
      end else if (a == OFS_LEN) begin
         v = {21'h0, s.listLen};
      end else if (a == OFS_DWELL) begin
         v = s.dwell;
      end else if (a == OFS_INDEX) begin
         v = {22'h0, s.editIdx};
      end else if (a == OFS_FREQ) begin
         v = w;
      end else if (a == OFS_STAT) begin
         v = {6'h0, s.pos, 14'h0, s.st != ST_INIT, s.busy};
      end
      return v;
   endfunction : fhsRead

   // Exponent of the largest power of two not above the length, held to 5..10.
   function automatic logic [3:0] fhsRandN(input logic [LEN_W-1:0] len);
      logic [3:0] k;
      k = RAND_N_MIN;
      for (int i = 6; i <= 10; i++) begin
         if (len >= (11'h001 << i)) begin
            k = 4'(i);
         end
      end
      return k;
   endfunction : fhsRandN

   always_comb begin
      wd = fhsMerge(fhsRead(r, r.awAddr, tableMem[r.editIdx]), r.wData, r.wStrb);
   end

   assign extEdge = r.ctrl.pol ? (r.trigPrev && !trigIn) : (!r.trigPrev && trigIn);
   assign lastPoint = {1'b0, r.pos} == r.lenLat - 11'h001;
   assign halfLen = LEN_W'((r.lenLat + 11'h001) >> 1);
   assign seqAddr = (r.randLat && r.pos != 10'h000) ? lfsrState : r.pos;

   // Whole next state: bus slave, table loader, trigger handling and pass sequencing.
   always_comb begin
      n = r;
      memWe = 1'b0;
      memAddr = r.editIdx;
      memWd = r.wData;
      advCmd = 1'b0;
      manCmd = 1'b0;
      pushValid = 1'b0;
      lfsrLoad = 1'b0;
      lfsrStep = 1'b0;
      n.trigPrev = trigIn;
      if (r.s2m.awready && axiIn.awvalid) begin
         n.awHave = 1'b1;
         n.awAddr = axiIn.awaddr;
      end
      if (r.s2m.wready && axiIn.wvalid) begin
         n.wHave = 1'b1;
         n.wData = axiIn.wdata;
         n.wStrb = axiIn.wstrb;
      end
      // A write completes once both address and data are held.
      if (r.awHave && r.wHave && !r.s2m.bvalid) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.s2m.bvalid = 1'b1;
         n.s2m.bresp = RESP_OKAY;
         if (r.awAddr == OFS_CTRL) begin
            n.ctrl = fhs_ctrl_s'(wd[CTRL_W-1:0]);
         end else if (r.awAddr == OFS_LEN) begin
            n.listLen = (wd == 32'h0) ? 11'h001 : (wd > {21'h0, LEN_MAX}) ? LEN_MAX : wd[LEN_W-1:0];
         end else if (r.awAddr == OFS_DWELL) begin
            n.dwell = (wd == 32'h0) ? 32'h0000_0001 : wd;
         end else if (r.awAddr == OFS_INDEX) begin
            n.editIdx = wd[IDX_W-1:0];
         end else if (r.awAddr == OFS_FREQ) begin
            memWe = 1'b1;
         end else if (r.awAddr == OFS_CMD) begin
            advCmd = wd[CMD_ADV_BIT];
            manCmd = wd[CMD_MAN_BIT];
         end else if (r.awAddr != OFS_STAT) begin
            n.s2m.bresp = RESP_SLVERR;
         end
      end else if (r.s2m.bvalid && axiIn.bready) begin
         n.s2m.bvalid = 1'b0;
      end
      if (advCmd) begin
         n.editIdx = r.editIdx + 10'h001;
      end
      if (r.s2m.arready && axiIn.arvalid) begin
         n.s2m.rvalid = 1'b1;
         n.s2m.rdata = fhsRead(r, axiIn.araddr, tableMem[r.editIdx]);
         n.s2m.rresp = fhsMapped(axiIn.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (r.s2m.rvalid && axiIn.rready) begin
         n.s2m.rvalid = 1'b0;
      end
      case (r.st)
         ST_INIT: begin
            memWe = 1'b1;
            memAddr = r.initIdx;
            memWd = ({22'h0, r.initIdx} + 32'h0000_0001) * KHZ_STEP;
            n.initIdx = r.initIdx + 10'h001;
            if (r.initIdx == 10'(TABLE_DEPTH - 1)) begin
               n.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (r.ctrl.run) begin
               if (r.ctrl.src == SRC_INT) begin
                  n.st = ST_PUSH;
               end else if (r.ctrl.src == SRC_MAN && r.manPend) begin
                  n.st = ST_PUSH;
                  n.manPend = 1'b0;
               end else if (r.ctrl.src == SRC_EXT && extEdge) begin
                  n.st = ST_PUSH;
               end
            end
         end
         ST_PUSH: begin
            pushValid = 1'b1;
            if (bufReady) begin
               n.st = ST_DWELL;
               n.dwellCnt = r.dwell - 32'h0000_0001;
            end
         end
         default: begin
            if (r.dwellCnt != 32'h0) begin
               n.dwellCnt = r.dwellCnt - 32'h0000_0001;
            end else if (lastPoint) begin
               n.busy = 1'b0;
               n.sync = 1'b0;
               n.st = (r.ctrl.src == SRC_INT) ? ST_PUSH : ST_IDLE;
            end else begin
               n.pos = r.pos + 10'h001;
               lfsrStep = r.randLat && r.pos != 10'h000;
               n.sync = ({1'b0, r.pos} + 11'h001) < halfLen;
               n.st = ST_PUSH;
            end
         end
      endcase
      // A pass starts whenever the sequencer enters PUSH from idle or from the end of the last pass.
      if (n.st == ST_PUSH && (r.st == ST_IDLE || (r.st == ST_DWELL && lastPoint && r.dwellCnt == 32'h0))) begin
         n.pos = 10'h000;
         n.randLat = r.ctrl.order;
         n.nLat = fhsRandN(r.listLen);
         n.lenLat = r.ctrl.order ? (11'h001 << fhsRandN(r.listLen)) : r.listLen;
         n.busy = 1'b1;
         n.sync = 1'b1;
         lfsrLoad = 1'b1;
      end
      // Clearing run aborts a pass at once; the pending manual trigger survives.
      if (!r.ctrl.run && r.st != ST_INIT) begin
         n.st = ST_IDLE;
         n.busy = 1'b0;
         n.sync = 1'b0;
      end
      // A manual command that lands while the last one is consumed is kept.
      if (manCmd) begin
         n.manPend = 1'b1;
      end
      n.echo = 1'b0;
      if (r.ctrl.src != SRC_EXT && r.ctrl.echo == ECHO_RISE) begin
         n.echo = n.busy;
      end else if (r.ctrl.src != SRC_EXT && r.ctrl.echo == ECHO_FALL) begin
         n.echo = !n.busy;
      end
      n.s2m.arready = !n.s2m.rvalid;
      n.s2m.awready = !n.awHave && !n.s2m.bvalid && n.st != ST_INIT;
      n.s2m.wready = !n.wHave && !n.s2m.bvalid && n.st != ST_INIT;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         r <= '{s2m: '{default: '0}, ctrl: '{echo: ECHO_OFF, src: SRC_INT, default: '0},
            listLen: LEN_RST, dwell: DWELL_RST, st: ST_INIT, lenLat: LEN_RST, nLat: RAND_N_MAX, default: '0};
      end else begin
         r <= n;
      end
   end

   // The table has no reset, so it is filled entry by entry after reset; bus writes wait meanwhile, reads are still served.
   always_ff @(posedge clock) begin
      if (memWe) begin
         tableMem[memAddr] <= memWd;
      end
   end

   fhs_lfsr u_lfsr (
      .clock(clock),
      .resetn(resetn),
      .load(lfsrLoad),
      .step(lfsrStep),
      .width(r.nLat),
      .state(lfsrState)
   );

   fhs_hop_buffer u_buffer (
      .clock(clock),
      .resetn(resetn),
      .inValid(pushValid),
      .inData(tableMem[seqAddr]),
      .inReady(bufReady),
      .outValid(freqValid),
      .outData(freqData),
      .outReady(freqReady)
   );

   assign axiOut = r.s2m;
   assign trigEcho = r.echo;
   assign syncOut = r.sync;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence s_lastDone;
      r.st == ST_DWELL && r.dwellCnt == 32'h0 && lastPoint && r.ctrl.run;
   endsequence
   sequence s_passRestart;
      r.st == ST_PUSH && r.pos == 10'h000 && r.sync;
   endsequence

   property p_initDone;
      r.st == ST_INIT && r.initIdx == 10'h3ff |=> r.st == ST_IDLE && $past(memWd) == 32'h000f_a000;
   endproperty
   a_initDone: assert property (p_initDone) else $error("table load did not end at 1024 kHz");
   property p_dwellLoad;
      r.st == ST_PUSH && bufReady && r.ctrl.run |=> r.st == ST_DWELL && r.dwellCnt == $past(r.dwell) - 32'h1;
   endproperty
   a_dwellLoad: assert property (p_dwellLoad) else $error("dwell count not loaded");
   property p_advance;
      r.st == ST_DWELL && r.dwellCnt == 32'h0 && !lastPoint && r.ctrl.run
         |=> r.st == ST_PUSH && r.pos == $past(r.pos) + 10'h001;
   endproperty
   a_advance: assert property (p_advance) else $error("point did not advance by one");
   property p_editInc;
      advCmd |=> r.editIdx == $past(r.editIdx) + 10'h001;
   endproperty
   a_editInc: assert property (p_editInc) else $error("edit index did not step");
   property p_randLen;
      r.busy && r.randLat |-> r.lenLat == (11'h001 << r.nLat) && r.nLat >= RAND_N_MIN && r.nLat <= RAND_N_MAX;
   endproperty
   a_randLen: assert property (p_randLen) else $error("random length not a power of two");
   property p_internal;
      s_lastDone and (r.ctrl.src == SRC_INT) |=> s_passRestart;
   endproperty
   a_internal: assert property (p_internal) else $error("internal source did not restart");
   property p_manualWait;
      r.st == ST_IDLE && r.ctrl.src == SRC_MAN && !r.manPend && !manCmd |=> r.st == ST_IDLE;
   endproperty
   a_manualWait: assert property (p_manualWait) else $error("manual pass without command");
   property p_extStart;
      r.st == ST_IDLE && r.ctrl.run && r.ctrl.src == SRC_EXT && (r.ctrl.pol ? $fell(trigIn) : $rose(trigIn))
         |=> s_passRestart;
   endproperty
   a_extStart: assert property (p_extStart) else $error("edge did not start a pass");
   property p_echoExt;
      r.ctrl.src == SRC_EXT ##1 r.ctrl.src == SRC_EXT |-> !trigEcho;
   endproperty
   a_echoExt: assert property (p_echoExt) else $error("echo driven under external source");
   property p_echoRise;
      $rose(r.busy) && r.ctrl.src != SRC_EXT && r.ctrl.echo == ECHO_RISE |-> trigEcho ##1 1'b1;
   endproperty
   a_echoRise: assert property (p_echoRise) else $error("rising echo not high at start");
   property p_syncStart;
      $rose(r.busy) |-> syncOut;
   endproperty
   a_syncStart: assert property (p_syncStart) else $error("sync not high at first point");
endmodule : fhs_sequencer
`default_nettype wire

/* fhs_pkg.sv */
// Constants, types and register map of the frequency hop list sequencer.
// Contract
// - After reset the table is filled with 1024 entries, entry k holding k kHz, from 1 kHz to 1024 kHz.
// - Each selected entry is output for one dwell interval set by the sample period, then the next follows; the code spends one cycle more per entry.
// - Software sets the list length, writes the entry at the edit index and can step that index by one.
// - In in-order mode the entries go out one by one from the first to the last active entry.
// - In pseudo-random mode the order follows a pseudo-random code and the length is 2 to the n, n from 5 to 10.
// - With the internal source, passes follow one another without waiting for any trigger.
// - With the manual source, each manual trigger command gives exactly one whole pass.
// - With the external source, each valid edge of the chosen polarity starts one whole pass.
// - Rising polarity starts on a 0-to-1 change and falling polarity on a 1-to-0 change.
// - The trigger echo is driven only with the internal or manual source and stays inactive otherwise; the code also drives it with SRC_NONE.
// - Echo off drives nothing; rising goes high at pass start and low at its end; falling the reverse. The code keeps it steady between internal passes.
// - Sync has one pass as period, rises at the first point and stays high for half the pass.
// - With external or manual triggering the sync timing follows the trigger events.
`default_nettype none
package fhs_pkg;
   localparam int TABLE_DEPTH = 1024;
   localparam int IDX_W = 10;
   localparam int LEN_W = 11;
   localparam int ADDR_W = 8;
   localparam int CTRL_W = 7;
   localparam logic [31:0] KHZ_STEP = 32'h0000_03e8;
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LEN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DWELL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INDEX = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h18;
   // Command bits of the command register.
   localparam int CMD_ADV_BIT = 0;
   localparam int CMD_MAN_BIT = 1;
   // Reset values, limits and response codes.
   localparam logic [LEN_W-1:0] LEN_RST = 11'h400;
   localparam logic [LEN_W-1:0] LEN_MAX = 11'h400;
   localparam logic [3:0] RAND_N_MIN = 4'h5;
   localparam logic [3:0] RAND_N_MAX = 4'ha;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Default sample period and its derived dwell count at the 40 MHz clock.
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int CLOCK_KHZ = 40000;
   localparam int DWELL_CYC = (SAMPLE_PERIOD_NS * CLOCK_KHZ) / 1000000 < 1 ? 1 :
      (SAMPLE_PERIOD_NS * CLOCK_KHZ) / 1000000;
   localparam logic [31:0] DWELL_RST = 32'(DWELL_CYC);

   typedef enum logic [1:0] {ST_INIT = 2'b00, ST_IDLE = 2'b01, ST_PUSH = 2'b10, ST_DWELL = 2'b11} fhs_state_e;
   typedef enum logic [1:0] {SRC_INT = 2'b00, SRC_MAN = 2'b01, SRC_EXT = 2'b10, SRC_NONE = 2'b11} fhs_src_e;
   typedef enum logic [1:0] {ECHO_OFF = 2'b00, ECHO_RISE = 2'b01, ECHO_FALL = 2'b10, ECHO_NONE = 2'b11} fhs_echo_e;

   typedef struct packed {
      fhs_echo_e echo;
      logic pol;
      fhs_src_e src;
      logic order;
      logic run;
   } fhs_ctrl_s;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } fhs_axi_m2s_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fhs_axi_s2m_s;

   typedef struct packed {
      fhs_axi_s2m_s s2m;
      logic awHave;
      logic [ADDR_W-1:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      fhs_ctrl_s ctrl;
      logic [LEN_W-1:0] listLen;
      logic [31:0] dwell;
      logic [IDX_W-1:0] editIdx;
      fhs_state_e st;
      logic [IDX_W-1:0] initIdx;
      logic [IDX_W-1:0] pos;
      logic [LEN_W-1:0] lenLat;
      logic randLat;
      logic [3:0] nLat;
      logic [31:0] dwellCnt;
      logic trigPrev;
      logic manPend;
      logic busy;
      logic echo;
      logic sync;
   } fhs_seq_s;
endpackage : fhs_pkg
`default_nettype wire

/* fhs_lfsr.sv */
// Maximal-length LFSR of selectable width 5 to 10 for the random hop order.
`default_nettype none
module fhs_lfsr import fhs_pkg::*; (
   input wire logic clock,
   input wire logic resetn,
   input wire logic load,
   input wire logic step,
   input wire logic [3:0] width,
   output logic [IDX_W-1:0] state
);
   typedef struct packed {
      logic [IDX_W-1:0] value;
   } fhs_lfsr_s;

   fhs_lfsr_s lfsr_reg;
   fhs_lfsr_s lfsr_next;

   // Feedback taps of a maximal sequence for each width; other widths fall back to ten.
   function automatic logic [IDX_W-1:0] fhsShift(input logic [IDX_W-1:0] v, input logic [3:0] w);
      logic fb;
      logic [IDX_W-1:0] mask;
      fb = 1'b0;
      mask = 10'h3ff;
      case (w)
         4'h5: begin fb = v[4] ^ v[2]; mask = 10'h01f; end
         4'h6: begin fb = v[5] ^ v[4]; mask = 10'h03f; end
         4'h7: begin fb = v[6] ^ v[5]; mask = 10'h07f; end
         4'h8: begin fb = v[7] ^ v[5] ^ v[4] ^ v[3]; mask = 10'h0ff; end
         4'h9: begin fb = v[8] ^ v[4]; mask = 10'h1ff; end
         default: begin fb = v[9] ^ v[6]; mask = 10'h3ff; end
      endcase
      return {v[IDX_W-2:0], fb} & mask;
   endfunction : fhsShift

   // The seed is one, so the register walks all nonzero codes of its width.
   always_comb begin
      lfsr_next = lfsr_reg;
      if (load) begin
         lfsr_next.value = 10'h001;
      end else if (step) begin
         lfsr_next.value = fhsShift(lfsr_reg.value, width);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         lfsr_reg <= '{value: 10'h001};
      end else begin
         lfsr_reg <= lfsr_next;
      end
   end

   assign state = lfsr_reg.value;

   property p_lfsrLive;
      @(posedge clock) disable iff (!resetn) step && !load |=> state != 10'h000 && state != $past(state);
   endproperty
   a_lfsrLive: assert property (p_lfsrLive) else $error("lfsr stuck or reached zero");
endmodule : fhs_lfsr
`default_nettype wire

/* fhs_hop_buffer.sv */
// Two-entry buffer between the sequencer and the frequency consumer.
`default_nettype none
module fhs_hop_buffer import fhs_pkg::*; (
   input wire logic clock,
   input wire logic resetn,
   input wire logic inValid,
   input wire logic [31:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [31:0] outData,
   input wire logic outReady
);
   typedef struct packed {
      logic [31:0] head;
      logic [31:0] tail;
      logic headV;
      logic tailV;
      logic inRdy;
   } fhs_buf_s;

   fhs_buf_s buf_reg;
   fhs_buf_s buf_next;
   logic pop;
   logic push;

   assign pop = buf_reg.headV && outReady;
   assign push = inValid && buf_reg.inRdy;

   // The head feeds the output directly; the tail only catches a word while the consumer stalls.
   always_comb begin
      buf_next = buf_reg;
      if (pop) begin
         buf_next.head = buf_reg.tail;
         buf_next.headV = buf_reg.tailV;
         buf_next.tailV = 1'b0;
      end
      if (push) begin
         if (!buf_next.headV) begin
            buf_next.head = inData;
            buf_next.headV = 1'b1;
         end else begin
            buf_next.tail = inData;
            buf_next.tailV = 1'b1;
         end
      end
      buf_next.inRdy = !buf_next.tailV;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         buf_reg <= '{head: 32'h0, tail: 32'h0, headV: 1'b0, tailV: 1'b0, inRdy: 1'b1};
      end else begin
         buf_reg <= buf_next;
      end
   end

   assign inReady = buf_reg.inRdy;
   assign outValid = buf_reg.headV;
   assign outData = buf_reg.head;

   property p_noLoss;
      @(posedge clock) disable iff (!resetn)
         push && buf_reg.headV && !pop |=> buf_reg.tailV && buf_reg.tail == $past(inData) && !inReady;
   endproperty
   a_noLoss: assert property (p_noLoss) else $error("stalled word not kept in tail");
endmodule : fhs_hop_buffer
`default_nettype wire

/* fhs_far_model.sv */
// Far-side stand-in: an edge trigger source and a frequency consumer that can stall.
`default_nettype none
module fhs_far_model (
   input wire logic clock,
   input wire logic fire,
   input wire logic stall,
   input wire logic pol,
   output logic trigIn,
   output logic freqReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pulseCnt = 3'h0;
   logic [1:0] phase = 2'h0;
   // A fire request makes a four-cycle pulse; the bench fires at most once per pass.
   always @(posedge clock) begin
      if (fire) pulseCnt <= 3'h4;
      else if (pulseCnt != 3'h0) pulseCnt <= pulseCnt - 3'h1;
      phase <= phase + 2'h1;
   end
   // The idle level follows pol, so the leading edge is rising or falling as asked.
   assign trigIn = (pulseCnt != 3'h0) ^ pol;
   // While stalling, the consumer refuses two cycles out of four, which exercises the buffer.
   assign freqReady = !stall || phase[1];
endmodule : fhs_far_model
`default_nettype wire

/* fhs_sequencer_tb.sv */
// Bench for the hop list sequencer: registers, list passes and trigger sources.
`default_nettype none
module fhs_sequencer_tb import fhs_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   fhs_axi_m2s_s m = '0;
   fhs_axi_s2m_s s;
   logic trigIn, trigEcho, syncOut, freqValid, freqReady;
   logic fire = 1'b0, stall = 1'b0, pol = 1'b0;
   logic [31:0] freqData, d, vals [4];
   logic [1:0] r;
   logic [31:0] q [$];
   bit seen [logic [31:0]];
   int fails = 0;
   int n_tests = 0;
   int sum, sHi, eHi, t0;
   fhs_sequencer fhs_sequencer_inst (.clock(clock), .resetn(resetn), .axiIn(m), .axiOut(s), .trigIn(trigIn),
      .trigEcho(trigEcho), .syncOut(syncOut), .freqValid(freqValid), .freqData(freqData), .freqReady(freqReady));
   fhs_far_model fhs_far_model_inst (.clock(clock), .fire(fire), .stall(stall), .pol(pol), .trigIn(trigIn),
      .freqReady(freqReady));
   // A half period of 12.5 ns gives the 40 MHz clock.
   always #12.5 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Address and data go out together and each drops once taken; bready stays high throughout.
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      m.awaddr <= a;
      m.wdata <= wd;
      m.wstrb <= 4'hf;
      m.awvalid <= 1'b1;
      m.wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s.awready === 1'b1) m.awvalid <= 1'b0;
         if (s.wready === 1'b1) m.wvalid <= 1'b0;
      end while (s.bvalid !== 1'b1);
      r = s.bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      m.araddr <= a;
      m.arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s.arready === 1'b1) m.arvalid <= 1'b0;
      end while (s.rvalid !== 1'b1);
      d = s.rdata;
      r = s.rresp;
   endtask : rd
   // Watches lim cycles, keeping up to n stream words and counting sync and echo high cycles.
   // The cycle of the first word is kept too, so a pass started by the wrong edge shows up late.
   task automatic grab(input int n, input int lim);
      q = {};
      sHi = 0;
      eHi = 0;
      t0 = 0;
      for (int k = 1; k <= lim; k++) begin
         @(posedge clock);
         if (freqValid === 1'b1 && freqReady === 1'b1 && t0 == 0) t0 = k;
         if (freqValid === 1'b1 && freqReady === 1'b1 && q.size() < n) q.push_back(freqData);
         if (syncOut === 1'b1) sHi++;
         if (trigEcho === 1'b1) eHi++;
      end
   endtask : grab
   // Stopping aborts the pass; words already buffered are drained so they cannot leak into the next test.
   task automatic halt();
      wr(OFS_CTRL, 32'h0);
      stall <= 1'b0;
      grab(0, 30);
   endtask : halt
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // Main sequence: table load, editing, then each trigger source and order.
   initial begin
      m.bready <= 1'b1;
      m.rready <= 1'b1;
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      while (d[1] !== 1'b1) rd(OFS_STAT);
      rd(OFS_FREQ);
      chk(d, KHZ_STEP);
      chk(32'(r), 32'(RESP_OKAY));
      wr(OFS_INDEX, 32'h0000_03ff);
      rd(OFS_FREQ);
      chk(d, 32'h000f_a000);
      wr(OFS_INDEX, 32'h0);
      for (int i = 0; i < 4; i++) begin
         vals[i] = 32'((10 - i) * 10000);
         wr(OFS_FREQ, vals[i]);
         wr(OFS_CMD, 32'h1);
      end
      rd(OFS_INDEX);
      chk(d, 32'h4);
      wr(OFS_LEN, 32'h4);
      wr(OFS_DWELL, 32'h2);
      wr(8'h1c, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
      stall <= 1'b1;
      wr(OFS_CTRL, 32'h21);
      grab(8, 200);
      for (int i = 0; i < 8; i++) chk(q[i], vals[i % 4]);
      chk(32'(eHi > 0), 32'h1);
      halt();
      wr(OFS_CTRL, 32'h45);
      wr(OFS_CMD, 32'h2);
      grab(8, 200);
      chk(32'(q.size()), 32'h4);
      chk(32'(sHi), 32'h6);
      chk(32'(eHi < 200 && trigEcho === 1'b1), 32'h1);
      // Both polarities: the trailing edge of each pulse must not start a second pass.
      for (int p = 0; p < 2; p++) begin
         halt();
         pol <= p[0];
         wr(OFS_CTRL, 32'h29 | 32'(p << 4));
         grab(4, 40);
         chk(32'(q.size()), 32'h0);
         fire <= 1'b1;
         @(posedge clock);
         fire <= 1'b0;
         grab(8, 200);
         chk(32'(q.size()), 32'h4);
         // The leading edge is seen one cycle after the pulse starts, so the first word shows on the third cycle.
         chk(32'(t0), 32'h3);
         chk(32'(sHi), 32'h6);
         chk(32'(eHi), 32'h0);
      end
      halt();
      wr(OFS_LEN, 32'h20);
      wr(OFS_CTRL, 32'h03);
      grab(32, 400);
      sum = 0;
      for (int i = 0; i < 32; i++) begin
         sum += int'(q[i]) - (i < 4 ? int'(vals[i]) : (i + 1) * 1000);
         seen[q[i]] = 1'b1;
      end
      chk(32'(seen.size()), 32'h20);
      chk(32'(sum), 32'h0);
      test_done();
   end
   // The whole run needs a few thousand cycles, so this limit only cuts a hang short.
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      test_done();
   end
endmodule : fhs_sequencer_tb
`default_nettype wire
